// *** rtl/clock_stop_spi.sv ***
`timescale 1ns/100ps
`include "clock_stop_cfg.svh"

module clock_stop_spi
   import clock_stop_pkg::*;
#(
   parameter int WORD_BITS = `WORD_BITS
) (
   // clock and reset
   input  wire logic                 clk_sys_i,
   input  wire logic                 rst_n_i,
   // configuration
   input  wire port_cfg_s            cfg_i,
   output port_dir_s                 dir_o,
   // user transmit side
   input  wire logic                 start_i,
   input  wire logic [WORD_BITS-1:0] tx_word_i,
   output logic                      busy_o,
   // user receive side
   output logic [WORD_BITS-1:0]      rx_word_o,
   output logic                      rx_valid_o,
   // external sample-rate source
   input  wire logic                 ext_source_clock_i,
   // transmit bit clock pin
   input  wire logic                 tx_bit_clock_i,
   output logic                      tx_bit_clock_o,
   output logic                      tx_bit_clock_oe_n_o,
   // transmit frame sync pin
   input  wire logic                 tx_frame_sync_i,
   output logic                      tx_frame_sync_o,
   output logic                      tx_frame_sync_oe_n_o,
   // receive pins
   input  wire logic                 rx_bit_clock_i,
   input  wire logic                 rx_frame_sync_i,
   input  wire logic                 serial_rx_line_i,
   // transmit data pin
   output logic                      serial_tx_line_o,
   output logic                      serial_tx_line_oe_n_o
);

   localparam int PW = `DIV_W + 2;
   localparam int CW = $clog2(WORD_BITS + 1);
   localparam int XW = $clog2(`TX_EXTRA_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [`SYNC_LANES-1:0] meta;
   logic [`SYNC_LANES-1:0] sync;
   logic [`SYNC_LANES-1:0] sync_q;
   logic [`SYNC_LANES-1:0] pins;

   assign pins = {ext_source_clock_i, serial_rx_line_i, rx_frame_sync_i,
                  rx_bit_clock_i, tx_frame_sync_i, tx_bit_clock_i};

   // two stages, then a third for edge detection
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta   <= '0;
         sync   <= '0;
         sync_q <= '0;
      end else begin
         meta   <= pins;
         sync   <= meta;
         sync_q <= sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode, directions and phase lengths

   logic          is_master;
   logic          code_half;
   logic          odd_or_zero;
   logic          half_tick;
   logic [PW-1:0] high_len;
   logic [PW-1:0] low_len;
   logic [PW-1:0] lead_len;

   assign is_master = cfg_i.master_mode;
   assign code_half = (cfg_i.clock_stop_code == `STOP_CODE_HALF);

   // master: tx clock and frame pins driven, rx pins sensed; slave: clock and frame pins all sensed
   assign dir_o.tx_clock_direction = is_master;
   assign dir_o.tx_frame_direction = is_master;
   assign dir_o.rx_clock_direction = 1'b0;
   assign dir_o.rx_frame_direction = 1'b0;
   assign tx_bit_clock_oe_n_o  = ~is_master;
   assign tx_frame_sync_oe_n_o = ~is_master;

   // a half tick is half a sample-rate period, at most one per cpu cycle
   assign half_tick = (cfg_i.srg_source_select == `SRG_SRC_CPU_HALF) ? 1'b1 :
                      (sync[`SYNC_EXT_SRC] ^ sync_q[`SYNC_EXT_SRC]);

   // lengths in half ticks: twice the input-period counts
   assign odd_or_zero = cfg_i.srg_divider[0] | (cfg_i.srg_divider == '0);
   assign high_len = odd_or_zero ? PW'(cfg_i.srg_divider) + PW'(1) :
                                   PW'(cfg_i.srg_divider) + PW'(2);
   assign low_len  = odd_or_zero ? PW'(cfg_i.srg_divider) + PW'(1) :
                                   PW'(cfg_i.srg_divider);
   assign lead_len = code_half ? low_len + high_len : low_len;

   ////////////////////////////////////////////////////////////////////////////
   // master sequencer

   master_state_e state;
   master_state_e next_state;
   logic [PW-1:0] lead_cnt;
   logic [CW-1:0] fall_cnt;
   logic          accept;
   logic          div_run;
   logic          div_level;
   logic          div_rise;
   logic          div_fall;
   logic          last_fall;
   logic          frame_tail;
   logic          frame_on;

   // select held one cycle past the last edge so the final bit is still framed
   assign frame_on  = (state != ST_IDLE) | frame_tail;
   assign accept    = (state == ST_IDLE) & ~frame_tail & is_master & start_i;
   assign last_fall = div_fall & (fall_cnt == CW'(WORD_BITS - 1));
   // clock starts once the select lead has elapsed
   assign div_run   = (state == ST_SHIFT) |
                      ((state == ST_LEAD) & (lead_cnt == '0));

   // sequencer transitions
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE:  if (accept) next_state = ST_LEAD;
         ST_LEAD:  if (half_tick && lead_cnt == '0) next_state = ST_SHIFT;
         ST_SHIFT: if (last_fall) next_state = ST_IDLE;
         default:  next_state = ST_IDLE;
      endcase
      if (!is_master) next_state = ST_IDLE;
   end

   // state and counters
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state      <= ST_IDLE;
         lead_cnt   <= '0;
         fall_cnt   <= '0;
         frame_tail <= 1'b0;
      end else begin
         state      <= next_state;
         frame_tail <= last_fall;
         if (accept) begin
            lead_cnt <= lead_len - PW'(1);
         end else if (state == ST_LEAD && half_tick && lead_cnt != '0) begin
            lead_cnt <= lead_cnt - PW'(1);
         end
         if (state != ST_SHIFT) begin
            fall_cnt <= '0;
         end else if (div_fall) begin
            fall_cnt <= fall_cnt + CW'(1);
         end
      end
   end

   bit_clock_divider #(
      .PW          (PW)
   ) u_divider (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .run_i       (div_run),
      .half_tick_i (half_tick),
      .high_len_i  (high_len),
      .low_len_i   (low_len),
      .level_o     (div_level),
      .rise_o      (div_rise),
      .fall_o      (div_fall)
   );

   // clock idles at its polarity level between frames
   assign tx_bit_clock_o  = div_level ^ cfg_i.tx_clock_polarity;
   // active select shown low when frame polarity is 1
   assign tx_frame_sync_o = frame_on ^ cfg_i.tx_frame_polarity;

   ////////////////////////////////////////////////////////////////////////////
   // transmit path

   logic                 tx_clk_lvl;
   logic                 tx_clk_lvl_q;
   logic                 tx_rise;
   logic                 tx_fall;
   logic                 tx_active;
   logic                 tx_active_q;
   logic                 frame_start;
   logic                 load;
   logic                 launch;
   logic [WORD_BITS-1:0] tx_src;
   logic [WORD_BITS-1:0] tx_shift;
   logic                 tx_first;
   logic                 stage_bit;
   logic [XW-1:0]        dly_cnt;

   assign tx_clk_lvl   = sync[`SYNC_TX_CLK] ^ cfg_i.tx_clock_polarity;
   assign tx_clk_lvl_q = sync_q[`SYNC_TX_CLK] ^ cfg_i.tx_clock_polarity;
   assign tx_rise = is_master ? div_rise : (tx_clk_lvl & ~tx_clk_lvl_q);
   assign tx_fall = is_master ? div_fall : (~tx_clk_lvl & tx_clk_lvl_q);
   // slave select is inverted here when tx frame polarity is 1
   assign tx_active = is_master ? frame_on :
                      (sync[`SYNC_TX_FS] ^ cfg_i.tx_frame_polarity);
   assign frame_start = tx_active & ~tx_active_q;
   assign load   = is_master ? accept : frame_start;
   assign launch = tx_active & (code_half ? (tx_fall | frame_start) : tx_rise);
   assign tx_src = load ? tx_word_i : tx_shift;
   assign busy_o = tx_active;

   // shift out msb first; first bit may carry the extra delay
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_active_q           <= 1'b0;
         tx_shift              <= '0;
         tx_first              <= 1'b0;
         stage_bit             <= 1'b0;
         dly_cnt               <= '0;
         serial_tx_line_o      <= 1'b0;
         serial_tx_line_oe_n_o <= 1'b1;
      end else begin
         tx_active_q           <= tx_active;
         serial_tx_line_oe_n_o <= ~tx_active;
         if (launch) begin
            stage_bit <= tx_src[WORD_BITS-1];
            tx_shift  <= tx_src << 1;
            tx_first  <= 1'b0;
            dly_cnt   <= ((load | tx_first) & cfg_i.tx_delay_enable) ?
                         XW'(`TX_EXTRA_CYCLES) : '0;
         end else begin
            if (load) begin
               tx_shift <= tx_word_i;
               tx_first <= 1'b1;
            end
            if (dly_cnt != '0) dly_cnt <= dly_cnt - XW'(1);
         end
         if (dly_cnt == '0) serial_tx_line_o <= stage_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive path

   logic                 rx_clk_lvl;
   logic                 rx_clk_lvl_q;
   logic                 rx_active;
   logic                 sample;
   logic [WORD_BITS-1:0] rx_shift;
   logic [WORD_BITS-1:0] rx_next;
   logic [CW-1:0]        rx_cnt;

   assign rx_clk_lvl   = sync[`SYNC_RX_CLK] ^ cfg_i.tx_clock_polarity;
   assign rx_clk_lvl_q = sync_q[`SYNC_RX_CLK] ^ cfg_i.tx_clock_polarity;
   assign rx_active = sync[`SYNC_RX_FS] ^ cfg_i.rx_frame_polarity;
   assign sample = rx_active & (code_half ? (rx_clk_lvl & ~rx_clk_lvl_q) :
                                            (~rx_clk_lvl & rx_clk_lvl_q));
   assign rx_next = {rx_shift[WORD_BITS-2:0], sync[`SYNC_RX_LINE]};

   // collect a word, hand it over with a one-cycle strobe
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_shift   <= '0;
         rx_cnt     <= '0;
         rx_word_o  <= '0;
         rx_valid_o <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         if (!rx_active) begin
            rx_cnt <= '0;
         end else if (sample) begin
            rx_shift <= rx_next;
            if (rx_cnt == CW'(WORD_BITS - 1)) begin
               rx_cnt     <= '0;
               rx_word_o  <= rx_next;
               rx_valid_o <= 1'b1;
            end else begin
               rx_cnt <= rx_cnt + CW'(1);
            end
         end
      end
   end

endmodule

// *** common/clock_stop_cfg.svh ***
`ifndef CLOCK_STOP_CFG_SVH
`define CLOCK_STOP_CFG_SVH

// cpu clock period
`define CPU_PERIOD_NS      10

// divider field width and default serial word length
`define DIV_W              8
`define WORD_BITS          8

// sample-rate source select codes
`define SRG_SRC_CPU_HALF   1'b1
`define SRG_SRC_EXTERNAL   1'b0

// clock-stop codes
`define STOP_CODE_NO_DELAY 2'b10
`define STOP_CODE_HALF     2'b11

// extra first-bit delay window, in cpu periods
`define TX_EXTRA_MIN_P     2
`define TX_EXTRA_MAX_P     4
`define TX_EXTRA_CYCLES    ((`TX_EXTRA_MIN_P + `TX_EXTRA_MAX_P) / 2)

// synchroniser lane positions
`define SYNC_TX_CLK        0
`define SYNC_TX_FS         1
`define SYNC_RX_CLK        2
`define SYNC_RX_FS         3
`define SYNC_RX_LINE       4
`define SYNC_EXT_SRC       5
`define SYNC_LANES         6

`endif

// *** common/clock_stop_pkg.sv ***
`include "clock_stop_cfg.svh"

package clock_stop_pkg;

   // static port configuration
   typedef struct packed {
      logic              master_mode;
      logic              srg_source_select;
      logic [`DIV_W-1:0] srg_divider;
      logic              tx_delay_enable;
      logic [1:0]        clock_stop_code;
      logic              tx_clock_polarity;
      logic              tx_frame_polarity;
      logic              rx_frame_polarity;
   } port_cfg_s;

   // clock/frame direction bits shown to the outside
   typedef struct packed {
      logic tx_clock_direction;
      logic tx_frame_direction;
      logic rx_clock_direction;
      logic rx_frame_direction;
   } port_dir_s;

   // master sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_LEAD  = 3'b010,
      ST_SHIFT = 3'b100
   } master_state_e;

endpackage

// *** rtl/bit_clock_divider.sv ***
`timescale 1ns/100ps

module bit_clock_divider #(
   parameter int PW = 10
) (
   // clock and reset
   input  wire logic          clk_sys_i,
   input  wire logic          rst_n_i,
   // control
   input  wire logic          run_i,
   input  wire logic          half_tick_i,
   input  wire logic [PW-1:0] high_len_i,
   input  wire logic [PW-1:0] low_len_i,
   // bit clock
   output logic               level_o,
   output logic               rise_o,
   output logic               fall_o
);

   logic [PW-1:0] cnt;
   logic          toggle;

   // phase ends when the count runs out on a half tick
   assign toggle = run_i & half_tick_i & (cnt == '0);
   assign rise_o = toggle & ~level_o;
   assign fall_o = toggle & level_o;

   // idle low; first half tick of a run raises the clock
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_o <= 1'b0;
         cnt     <= '0;
      end else if (!run_i) begin
         level_o <= 1'b0;
         cnt     <= '0;
      end else if (toggle) begin
         level_o <= ~level_o;
         cnt     <= (level_o ? low_len_i : high_len_i) - PW'(1);
      end else if (half_tick_i) begin
         cnt     <= cnt - PW'(1);
      end
   end

endmodule

// *** test/clock_stop_spi_asserts.sv ***
`timescale 1ns/100ps

module clock_stop_spi_chk
   import clock_stop_pkg::*;
(
   // clock and reset
   input wire logic      clk_sys_i,
   input wire logic      rst_n_i,
   // watched ports
   input wire port_cfg_s cfg_i,
   input wire port_dir_s dir_o,
   input wire logic      start_i,
   input wire logic      busy_o,
   input wire logic      tx_bit_clock_o,
   input wire logic      tx_bit_clock_oe_n_o,
   input wire logic      tx_frame_sync_o,
   input wire logic      tx_frame_sync_oe_n_o,
   input wire logic      serial_tx_line_o,
   input wire logic      serial_tx_line_oe_n_o
);
   default clocking dc @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // mode decodes
   wire mst  = cfg_i.master_mode;
   wire c10  = mst && cfg_i.clock_stop_code == 2'b10 && !cfg_i.tx_clock_polarity;
   wire c11  = mst && cfg_i.clock_stop_code == 2'b11 && !cfg_i.tx_clock_polarity;
   wire div1 = mst && cfg_i.srg_source_select && cfg_i.srg_divider == 8'h01 && !cfg_i.tx_clock_polarity;
   wire go   = mst && !busy_o && start_i;

   a_master_dirs: assert property (mst |-> dir_o == 4'hc && !tx_bit_clock_oe_n_o && !tx_frame_sync_oe_n_o)
      else $error("master directions wrong");
   a_slave_dirs: assert property (!mst |-> dir_o == 4'h0 && tx_bit_clock_oe_n_o && tx_frame_sync_oe_n_o)
      else $error("slave directions wrong");
   a_select_start: assert property (go |=> tx_frame_sync_o == !cfg_i.tx_frame_polarity)
      else $error("select not active after start");
   a_select_idle: assert property (mst && !busy_o |-> tx_frame_sync_o == cfg_i.tx_frame_polarity)
      else $error("select active while idle");
   a_high_phase: assert property (div1 && $rose(tx_bit_clock_o) |-> tx_bit_clock_o [*2] ##1 !tx_bit_clock_o)
      else $error("high phase length wrong");
   a_low_phase: assert property (div1 && $fell(tx_bit_clock_o) |-> !tx_bit_clock_o [*2])
      else $error("low phase too short");
   a_lead_low: assert property (div1 && c10 && go |-> ##3 $rose(tx_bit_clock_o))
      else $error("first edge not one low phase after select");
   a_lead_full: assert property (div1 && c11 && go |-> ##5 $rose(tx_bit_clock_o))
      else $error("first edge not one period after select");
   a_launch_rise: assert property (c10 && !cfg_i.tx_delay_enable && !serial_tx_line_oe_n_o
      && $changed(serial_tx_line_o) |-> $past(tx_bit_clock_o, 1) && !$past(tx_bit_clock_o, 2))
      else $error("data not launched on rising edge");
   a_launch_fall: assert property (c11 && !cfg_i.tx_delay_enable && $past(busy_o, 4)
      && $changed(serial_tx_line_o) |-> !$past(tx_bit_clock_o, 1) && $past(tx_bit_clock_o, 2))
      else $error("data not launched on falling edge");
endmodule

bind clock_stop_spi clock_stop_spi_chk i_clock_stop_spi_chk (.*);

// *** test/spi_peer_model.sv ***
`timescale 1ns/100ps

module spi_peer_model (
   // bus pins
   input  wire logic       sclk_i,
   input  wire logic       sel_n_i,
   input  wire logic       mosi_i,
   // setup
   input  wire logic [1:0] code_i,
   input  wire logic [7:0] reply_i,
   // peer side
   output logic            miso_o,
   output logic [7:0]      got_o
);
   int idx = 0;

   initial miso_o = 1'b0;
   initial got_o = 8'h00;

   // select opens the frame, late code shows the msb at once
   always @(negedge sel_n_i) begin
      idx = 0;
      if (code_i == 2'b11) begin
         miso_o = reply_i[7];
         idx = 1;
      end
   end

   // launch on one edge, sample on the other
   always @(sclk_i) begin
      if (!sel_n_i) begin
         if (sclk_i == (code_i != 2'b11)) begin
            if (idx < 8) miso_o = reply_i[7 - idx];
            idx++;
         end else begin
            got_o = {got_o[6:0], mosi_i};
         end
      end
   end

   // released line shows the inverse of its last bit
   always @(posedge sel_n_i) miso_o = ~miso_o;
endmodule

// *** test/clock_stop_spi_tb.sv ***
`timescale 1ns/100ps

module clock_stop_spi_tb import clock_stop_pkg::*; ();
   logic       clk_sys_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       ext_clk = 1'b0;
   port_cfg_s  cfg = '0;
   port_dir_s  dir;
   logic       start = 1'b0;
   logic       busy, rx_valid, miso, mosi, mosi_oe_n;
   logic       sck_out, sck_oe_n, sel_out, sel_oe_n;
   logic       tb_sck = 1'b0;
   logic       tb_sel_n = 1'b1;
   logic [7:0] tx_word = 8'h00;
   logic [7:0] reply = 8'h00;
   logic [7:0] rx_word, got;
   logic [7:0] rx_seen = 8'h00;
   int         failures = 0;
   int         n_tests = 0;
   int         n, h, l;
   wire        sck = sck_oe_n ? tb_sck : sck_out;
   wire        sel_n = sel_oe_n ? tb_sel_n : sel_out;
   wire        mosi_pin = mosi_oe_n ? ~mosi : mosi;

   always #5 clk_sys_i = ~clk_sys_i;
   always #30 ext_clk = ~ext_clk;

   clock_stop_spi #(.WORD_BITS(8)) i_clock_stop_spi (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_i(cfg), .dir_o(dir),
      .start_i(start), .tx_word_i(tx_word), .busy_o(busy), .rx_word_o(rx_word),
      .rx_valid_o(rx_valid), .ext_source_clock_i(ext_clk), .tx_bit_clock_i(sck),
      .tx_bit_clock_o(sck_out), .tx_bit_clock_oe_n_o(sck_oe_n), .tx_frame_sync_i(sel_n),
      .tx_frame_sync_o(sel_out), .tx_frame_sync_oe_n_o(sel_oe_n), .rx_bit_clock_i(sck),
      .rx_frame_sync_i(sel_n), .serial_rx_line_i(miso), .serial_tx_line_o(mosi),
      .serial_tx_line_oe_n_o(mosi_oe_n));

   spi_peer_model i_spi_peer_model (.sclk_i(sck), .sel_n_i(sel_n), .mosi_i(mosi_pin),
      .code_i(cfg.clock_stop_code), .reply_i(reply), .miso_o(miso), .got_o(got));

   // keep the last received word
   always @(posedge clk_sys_i) if (rx_valid) rx_seen <= rx_word;

   ////////////////////////////////////////////////////////////
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task cycles(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask

   // negedges spent with the bit clock at lvl
   task phase(input logic lvl, output int cnt);
      cnt = 0;
      while (sck_out === lvl && cnt < 500) begin
         @(negedge clk_sys_i);
         cnt++;
      end
   endtask

   // negedges until the data line changes
   task launch(output int cnt);
      logic prev;
      prev = mosi;
      cnt = 0;
      while (mosi === prev && cnt < 50) begin
         @(negedge clk_sys_i);
         cnt++;
      end
   endtask

   task go(input logic [7:0] w);
      @(posedge clk_sys_i);
      tx_word <= w;
      start <= 1'b1;
      @(posedge clk_sys_i);
      start <= 1'b0;
      phase(1'b0, n);
   endtask

   task idle;
      n = 0;
      while (busy !== 1'b0 && n < 500) begin
         @(negedge clk_sys_i);
         n++;
      end
      check("frame end", {7'h00, busy}, 8'h00);
      cycles(12);
   endtask

   task xfer(input logic [1:0] code, input logic dly, input logic [7:0] w, input logic [7:0] r);
      cfg.clock_stop_code <= code;
      cfg.tx_delay_enable <= dly;
      reply <= r;
      go(w);
      if (code == 2'b10) begin
         launch(h);
         check("first launch", 8'(h), dly ? 8'h04 : 8'h01);
         phase(1'b1, n);
         phase(1'b0, n);
         launch(h);
         check("next launch", 8'(h), 8'h01);
      end
      idle();
      check("peer got", got, w);
      check("rx word", rx_seen, r);
   endtask

   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      #100us;
      failures++;
      stop_test();
   end

   initial begin
      cfg.master_mode = 1'b1;
      cfg.srg_source_select = 1'b1;
      cfg.srg_divider = 8'h01;
      cfg.clock_stop_code = 2'b10;
      cfg.tx_frame_polarity = 1'b1;
      cfg.rx_frame_polarity = 1'b1;
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      cycles(4);
      check("dir master", 8'(dir), 8'h0c);
      // bit clock phases for dividers 0 to 5
      for (int d = 0; d < 6; d++) begin
         cfg.srg_divider <= 8'(d);
         go(8'h5a);
         phase(1'b1, h);
         phase(1'b0, l);
         check("high phase", 8'(h), (d % 2 == 1 || d == 0) ? 8'(d + 1) : 8'(d + 2));
         check("low phase", 8'(l), (d % 2 == 1 || d == 0) ? 8'(d + 1) : 8'(d));
         idle();
      end
      $display("test dividers done");
      cfg.srg_source_select <= 1'b0;
      cfg.srg_divider <= 8'h01;
      go(8'h5a);
      phase(1'b1, h);
      phase(1'b0, l);
      check("ext high", 8'(h), 8'h06);
      check("ext low", 8'(l), 8'h06);
      idle();
      cfg.srg_source_select <= 1'b1;
      $display("test source done");
      cfg.srg_divider <= 8'h05;
      xfer(2'b10, 1'b0, 8'ha6, 8'h3c);
      cfg.srg_divider <= 8'h01;
      xfer(2'b11, 1'b0, 8'h96, 8'hc5);
      cfg.srg_divider <= 8'h05;
      xfer(2'b10, 1'b1, 8'ha6, 8'h69);
      $display("test master done");
      cfg.master_mode <= 1'b0;
      cfg.srg_divider <= 8'h01;
      cfg.clock_stop_code <= 2'b10;
      cfg.tx_delay_enable <= 1'b0;
      reply <= 8'h71;
      tx_word <= 8'hb4;
      cycles(2);
      check("dir slave", 8'(dir), 8'h00);
      tb_sel_n <= 1'b0;
      cycles(20);
      repeat (8) begin
         tb_sck <= 1'b1;
         cycles(20);
         tb_sck <= 1'b0;
         cycles(20);
      end
      tb_sel_n <= 1'b1;
      cycles(20);
      check("slave got", got, 8'hb4);
      check("slave rx", rx_seen, 8'h71);
      $display("test slave done");
      stop_test();
   end
endmodule
